/* File: verilog/bld_exec.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bld_defs.svh"

// Summary of operation
// - true condition loads direct address into PC
// - false condition continues with next instruction
// - indirect jump loads PC from register pair
// - direct jump: three bytes, eight cycles, nibble D
// - indirect jump: opcode 30, two bytes, eight cycles
// - these instructions never write the flags
// - true relative condition adds displacement to PC
// - displacement is a signed byte
// - displacement base is the following instruction
// - relative jump: two bytes, six cycles, nibble B
// - false relative condition falls through
// - load copies source, source left intact
module bld_exec
   import bld_pkg::*;
#(
   parameter logic [3:0] WORK_BASE = 4'hc  // page of working registers
) (
   input  wire logic        clock,          // core clock
   input  wire logic        rst_n,          // async reset, active low
   input  wire logic        start_valid,    // decoded instruction offered
   input  wire logic [7:0]  op_byte,        // first instruction byte
   input  wire logic [7:0]  arg1,           // second instruction byte
   input  wire logic [7:0]  arg2,           // third instruction byte
   input  wire logic [15:0] pc_in,          // address of first byte
   input  wire logic [7:0]  flags_in,       // flag register contents
   input  wire logic [7:0]  rf_rd_data,     // register file read data
   output var  logic        ready,          // idle, may take a start
   output var  logic        done,           // instruction complete pulse
   output var  logic        illegal,        // unsupported opcode pulse
   output var  logic        pc_load,        // load pc_out into PC
   output var  logic [15:0] pc_out,         // next program counter
   output var  logic        rf_rd_en,       // register read request
   output var  logic [7:0]  rf_rd_addr,     // register read address
   output var  logic        rf_wr_en,       // register write pulse
   output var  logic [7:0]  rf_wr_addr,     // register write address
   output var  logic [7:0]  rf_wr_data,     // register write data
   output var  logic        flags_wr_en     // flag write, never raised
);

   bld_state_t  state_reg,   state_next;
   bld_kind_t   kind_reg,    kind_next;
   logic [3:0]  cyc_reg,     cyc_next;
   logic [3:0]  step_reg,    step_next;
   logic [15:0] target_reg,  target_next;
   logic [7:0]  dst_reg,     dst_next;
   logic [7:0]  data_reg,    data_next;
   logic        ready_reg,   ready_next;
   logic        done_reg,    done_next;
   logic        illegal_reg, illegal_next;
   logic        pcld_reg,    pcld_next;
   logic [15:0] pcout_reg,   pcout_next;
   logic        rden_reg,    rden_next;
   logic [7:0]  rdaddr_reg,  rdaddr_next;
   logic        wren_reg,    wren_next;
   logic [7:0]  wraddr_reg,  wraddr_next;
   logic [7:0]  wrdata_reg,  wrdata_next;
   logic        flagwe_reg;

   logic        cond_true;
   logic        accept;
   logic [15:0] disp_ext;

   bld_cond u_cond (
      .condition_field (op_byte[7:4]),
      .flags           (flags_in),
      .taken           (cond_true)
   );

   assign accept   = start_valid && (state_reg == BLD_ST_IDLE);
   assign disp_ext = {{8{arg1[7]}}, arg1};

   always_comb begin
      state_next   = state_reg;
      kind_next    = kind_reg;
      cyc_next     = cyc_reg;
      step_next    = step_reg;
      target_next  = target_reg;
      dst_next     = dst_reg;
      data_next    = data_reg;
      ready_next   = ready_reg;
      done_next    = 1'b0;
      illegal_next = 1'b0;
      pcld_next    = 1'b0;
      pcout_next   = pcout_reg;
      rden_next    = 1'b0;
      rdaddr_next  = rdaddr_reg;
      wren_next    = 1'b0;
      wraddr_next  = wraddr_reg;
      wrdata_next  = wrdata_reg;
      case (state_reg)
         BLD_ST_IDLE: begin
            if (accept) begin
               state_next = BLD_ST_RUN;
               ready_next = 1'b0;
               step_next  = `BLD_STEP_ONE;
               if (op_byte == `BLD_OPC_JMP_PAIR) begin
                  kind_next   = BLD_K_JMP_PAIR;
                  cyc_next    = `BLD_CYC_JMP_PAIR;
                  rden_next   = 1'b1;
                  rdaddr_next = arg1;
               end else if (op_byte[3:0] == `BLD_OPC_JMP_DIR_LO) begin
                  kind_next = BLD_K_JMP_DIR;
                  cyc_next  = `BLD_CYC_JMP_DIR;
                  if (cond_true) begin
                     target_next = {arg1, arg2};
                  end else begin
                     target_next = pc_in + `BLD_LEN_JMP_DIR;
                  end
               end else if (op_byte[3:0] == `BLD_OPC_REL_LO) begin
                  kind_next = BLD_K_REL;
                  cyc_next  = `BLD_CYC_REL;
                  if (cond_true) begin
                     target_next = pc_in + `BLD_LEN_REL + disp_ext;
                  end else begin
                     target_next = pc_in + `BLD_LEN_REL;
                  end
               end else if (op_byte[3:0] == `BLD_OPC_MOV_REG_LO) begin
                  kind_next   = BLD_K_MOV_REG;
                  cyc_next    = `BLD_CYC_MOV;
                  target_next = pc_in + `BLD_LEN_MOV;
                  dst_next    = {WORK_BASE, op_byte[7:4]};
                  rden_next   = 1'b1;
                  rdaddr_next = arg1;
               end else if (op_byte[3:0] == `BLD_OPC_MOV_IMM_LO) begin
                  kind_next   = BLD_K_MOV_IMM;
                  cyc_next    = `BLD_CYC_MOV;
                  target_next = pc_in + `BLD_LEN_MOV;
                  dst_next    = {WORK_BASE, op_byte[7:4]};
                  data_next   = arg1;
               end else begin
                  // unsupported opcode: refused, block stays idle
                  state_next   = BLD_ST_IDLE;
                  ready_next   = 1'b1;
                  illegal_next = 1'b1;
               end
            end
         end
         BLD_ST_RUN: begin
            step_next = step_reg + `BLD_STEP_ONE;
            if (step_reg == `BLD_STEP_FIRST) begin
               if (kind_reg == BLD_K_JMP_PAIR) begin
                  target_next[15:8] = rf_rd_data;
                  rden_next         = 1'b1;
                  rdaddr_next       = rdaddr_reg | `BLD_PAIR_LO_BIT;
               end else if (kind_reg == BLD_K_MOV_REG) begin
                  data_next = rf_rd_data;
               end
            end
            if (step_reg == `BLD_STEP_SECOND &&
                kind_reg == BLD_K_JMP_PAIR) begin
               target_next[7:0] = rf_rd_data;
            end
            if (step_reg == cyc_reg - `BLD_STEP_ONE) begin
               state_next = BLD_ST_FIN;
               done_next  = 1'b1;
               pcld_next  = 1'b1;
               pcout_next = target_next;
               if (kind_reg == BLD_K_MOV_REG ||
                   kind_reg == BLD_K_MOV_IMM) begin
                  // only the destination is written
                  wren_next   = 1'b1;
                  wraddr_next = dst_reg;
                  wrdata_next = data_next;
               end
            end
         end
         BLD_ST_FIN: begin
            state_next = BLD_ST_IDLE;
            ready_next = 1'b1;
         end
         default: begin
            state_next = BLD_ST_IDLE;
            ready_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= BLD_ST_IDLE;
         kind_reg    <= BLD_K_JMP_DIR;
         cyc_reg     <= 4'h0;
         step_reg    <= 4'h0;
         target_reg  <= `BLD_PC_RESET;
         dst_reg     <= `BLD_BYTE_ZERO;
         data_reg    <= `BLD_BYTE_ZERO;
         ready_reg   <= 1'b1;
         done_reg    <= 1'b0;
         illegal_reg <= 1'b0;
         pcld_reg    <= 1'b0;
         pcout_reg   <= `BLD_PC_RESET;
         rden_reg    <= 1'b0;
         rdaddr_reg  <= `BLD_BYTE_ZERO;
         wren_reg    <= 1'b0;
         wraddr_reg  <= `BLD_BYTE_ZERO;
         wrdata_reg  <= `BLD_BYTE_ZERO;
         flagwe_reg  <= 1'b0;
      end else begin
         state_reg   <= state_next;
         kind_reg    <= kind_next;
         cyc_reg     <= cyc_next;
         step_reg    <= step_next;
         target_reg  <= target_next;
         dst_reg     <= dst_next;
         data_reg    <= data_next;
         ready_reg   <= ready_next;
         done_reg    <= done_next;
         illegal_reg <= illegal_next;
         pcld_reg    <= pcld_next;
         pcout_reg   <= pcout_next;
         rden_reg    <= rden_next;
         rdaddr_reg  <= rdaddr_next;
         wren_reg    <= wren_next;
         wraddr_reg  <= wraddr_next;
         wrdata_reg  <= wrdata_next;
         flagwe_reg  <= 1'b0;
      end
   end

   assign ready       = ready_reg;
   assign done        = done_reg;
   assign illegal     = illegal_reg;
   assign pc_load     = pcld_reg;
   assign pc_out      = pcout_reg;
   assign rf_rd_en    = rden_reg;
   assign rf_rd_addr  = rdaddr_reg;
   assign rf_wr_en    = wren_reg;
   assign rf_wr_addr  = wraddr_reg;
   assign rf_wr_data  = wrdata_reg;
   assign flags_wr_en = flagwe_reg;

   logic        acc_dir, acc_rel, acc_pair, acc_mov;
   logic [15:0] dir_addr, seq_dir, seq_rel, rel_dest;

   assign acc_dir  = accept && op_byte[3:0] == `BLD_OPC_JMP_DIR_LO;
   assign acc_rel  = accept && op_byte[3:0] == `BLD_OPC_REL_LO;
   assign acc_pair = accept && op_byte == `BLD_OPC_JMP_PAIR;
   assign acc_mov  = accept && op_byte[3:0] == `BLD_OPC_MOV_REG_LO;
   assign dir_addr = {arg1, arg2};
   assign seq_dir  = pc_in + `BLD_LEN_JMP_DIR;
   assign seq_rel  = pc_in + `BLD_LEN_REL;
   assign rel_dest = seq_rel + {{8{arg1[7]}}, arg1};
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   dir_take_a: assert property (
      acc_dir && cond_true |-> ##8 (done_reg && pc_load &&
                                    pc_out == $past(dir_addr, 8)))
      else $error("direct jump taken to wrong address or cycle");
   dir_skip_a: assert property (
      acc_dir && !cond_true |-> ##8 (pc_load && pc_out == $past(seq_dir, 8)))
      else $error("untaken direct jump did not fall through");
   dir_timing_a: assert property (
      acc_dir |=> !done_reg [*7] ##1 done_reg)
      else $error("direct jump not eight cycles");
   pair_target_a: assert property (
      acc_pair |-> ##8 (pc_load &&
         pc_out == {$past(rf_rd_data, 6), $past(rf_rd_data, 4)}))
      else $error("indirect jump target not from register pair");
   pair_order_a: assert property (
      acc_pair |-> ##1 (rf_rd_en && rf_rd_addr == $past(arg1))
              ##2 (rf_rd_en && rf_rd_addr == ($past(arg1, 3) | 8'h01)))
      else $error("register pair read order wrong");
   rel_take_a: assert property (
      acc_rel && cond_true |-> ##6 (done_reg &&
                                    pc_out == $past(rel_dest, 6)))
      else $error("relative jump target wrong");
   rel_skip_a: assert property (
      acc_rel && !cond_true |-> ##6 (done_reg && pc_out == $past(seq_rel, 6)))
      else $error("untaken relative jump did not fall through");
   flags_kept_a: assert property (
      !flags_wr_en)
      else $error("flag write raised");
   mov_copy_a: assert property (
      acc_mov |-> ##4 (rf_wr_en && rf_wr_data == $past(rf_rd_data, 2)))
      else $error("load did not copy source value");
   cond_table_a: assert property (
      accept |-> ((op_byte[7:4] != 4'h8 || cond_true) &&
                  (op_byte[7:4] != 4'h0 || !cond_true) &&
                  (op_byte[7:4] != 4'h7 || cond_true == flags_in[7])))
      else $error("condition evaluation wrong");
   dir_taken_c: cover property (acc_dir && cond_true);
   rel_back_c:  cover property (acc_rel && cond_true && arg1[7]);
   pair_c:      cover property (acc_pair ##8 done_reg);
   mov_c:       cover property (acc_mov ##4 rf_wr_en);

endmodule
`default_nettype wire

/* File: verilog/bld_defs.svh */
`ifndef BLD_DEFS_SVH
`define BLD_DEFS_SVH

// opcode encodings (low nibble of the first byte unless whole byte)
`define BLD_OPC_JMP_PAIR    8'h30
`define BLD_OPC_JMP_DIR_LO  4'hd
`define BLD_OPC_REL_LO      4'hb
`define BLD_OPC_MOV_REG_LO  4'h8
`define BLD_OPC_MOV_IMM_LO  4'hc

// instruction lengths in bytes
`define BLD_LEN_JMP_DIR     16'h0003
`define BLD_LEN_JMP_PAIR    16'h0002
`define BLD_LEN_REL         16'h0002
`define BLD_LEN_MOV         16'h0002

// execution lengths in core cycles
`define BLD_CYC_JMP_DIR     4'h8
`define BLD_CYC_JMP_PAIR    4'h8
`define BLD_CYC_REL         4'h6
`define BLD_CYC_MOV         4'h4

// cycle numbers (after acceptance) at which read data is captured, and the step increment
`define BLD_STEP_FIRST      4'h2
`define BLD_STEP_SECOND     4'h4
`define BLD_STEP_ONE        4'h1

// flag register bit positions
`define BLD_FLAG_C          7
`define BLD_FLAG_Z          6
`define BLD_FLAG_S          5
`define BLD_FLAG_V          4

// odd partner of an even register pair address
`define BLD_PAIR_LO_BIT     8'h01
`define BLD_PC_RESET        16'h0000
`define BLD_BYTE_ZERO       8'h00

`endif

/* File: verilog/bld_pkg.sv */
package bld_pkg;

   typedef enum logic [2:0] {
      BLD_ST_IDLE = 3'b001,
      BLD_ST_RUN  = 3'b010,
      BLD_ST_FIN  = 3'b100
   } bld_state_t;

   typedef enum logic [2:0] {
      BLD_K_JMP_DIR  = 3'h0,
      BLD_K_JMP_PAIR = 3'h1,
      BLD_K_REL      = 3'h2,
      BLD_K_MOV_REG  = 3'h3,
      BLD_K_MOV_IMM  = 3'h4
   } bld_kind_t;

endpackage

/* File: verilog/bld_cond.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bld_defs.svh"

module bld_cond (
   input  wire logic [3:0] condition_field, // condition nibble
   input  wire logic [7:0] flags,           // current flag register
   output var  logic       taken            // condition holds
);
   logic c;
   logic z;
   logic s;
   logic v;
   logic base;

   assign c = flags[`BLD_FLAG_C];
   assign z = flags[`BLD_FLAG_Z];
   assign s = flags[`BLD_FLAG_S];
   assign v = flags[`BLD_FLAG_V];

   // lower eight codes; the upper eight are their complements
   always_comb begin
      case (condition_field[2:0])
         3'h0:    base = 1'b0;
         3'h1:    base = s ^ v;
         3'h2:    base = z | (s ^ v);
         3'h3:    base = c | z;
         3'h4:    base = v;
         3'h5:    base = s;
         3'h6:    base = z;
         3'h7:    base = c;
         default: base = 1'b0;
      endcase
      taken = base ^ condition_field[3];
   end

endmodule
`default_nettype wire

/* File: tb/bld_rf_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bld_rf_model (
   input  wire logic       clock,   // core clock
   input  wire logic       rst_n,   // async reset, active low
   input  wire logic       rd_en,   // read strobe
   input  wire logic [7:0] rd_addr, // read address
   output var  logic [7:0] rd_data, // data in the cycle after the strobe
   input  wire logic       wr_en,   // write strobe
   input  wire logic [7:0] wr_addr, // write address
   input  wire logic [7:0] wr_data  // write data
);
   logic [7:0] mem [0:255];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h5a;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end else begin
         rd_data <= ~rd_data; // stale data inverted each idle cycle, equal to the read value again every second one
      end
   end
   always @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("FAIL %s exp %0h got %0h", nm, e, g); \
   end \
end
module tb_top;
   logic        clock, rst_n, start_valid, ready, done, illegal, pc_load;
   logic [7:0]  op_byte, arg1, arg2, flags_in, rf_rd_data, rf_rd_addr;
   logic [15:0] pc_in, pc_out, epc;
   logic        rf_rd_en, rf_wr_en, flags_wr_en;
   logic [7:0]  rf_wr_addr, rf_wr_data, fl, a1, a2, src, ewd;
   logic [3:0]  dn;
   logic [7:0]  ref_mem [0:255];
   int          error_cnt, checks_done, cyc_cnt, i;

   bld_exec dut (.clock(clock), .rst_n(rst_n), .start_valid(start_valid),
      .op_byte(op_byte), .arg1(arg1), .arg2(arg2), .pc_in(pc_in),
      .flags_in(flags_in), .rf_rd_data(rf_rd_data), .ready(ready),
      .done(done), .illegal(illegal), .pc_load(pc_load), .pc_out(pc_out),
      .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr), .rf_wr_en(rf_wr_en),
      .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
      .flags_wr_en(flags_wr_en));
   bld_rf_model rf (.clock(clock), .rst_n(rst_n), .rd_en(rf_rd_en),
      .rd_addr(rf_rd_addr), .rd_data(rf_rd_data), .wr_en(rf_wr_en),
      .wr_addr(rf_wr_addr), .wr_data(rf_wr_data));

   function automatic logic cond(input logic [3:0] code, input logic [7:0] f);
      logic b;
      case (code[2:0])
         3'h0: b = 1'b0;
         3'h1: b = f[5] ^ f[4];
         3'h2: b = f[6] | (f[5] ^ f[4]);
         3'h3: b = f[7] | f[6];
         3'h4: b = f[4];
         3'h5: b = f[5];
         3'h6: b = f[6];
         default: b = f[7];
      endcase
      return b ^ code[3];
   endfunction

   task automatic test_done();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // offers one instruction, scribbles on start_valid, op_byte, arg1 and flags_in while busy
   task automatic run(input logic [7:0] op, b1, b2, input logic [15:0] pc,
                      input logic [7:0] f, input int cyc,
                      input logic [15:0] ep, input logic ewr,
                      input logic [7:0] ewa, input logic [7:0] ewdat);
      int n;
      n = 0;
      @(posedge clock);
      op_byte <= op;
      arg1 <= b1;
      arg2 <= b2;
      pc_in <= pc;
      flags_in <= f;
      start_valid <= 1'b1;
      @(posedge clock);
      do begin
         start_valid <= 1'($urandom);
         op_byte <= 8'($urandom);
         arg1 <= 8'($urandom);
         flags_in <= 8'($urandom);
         @(posedge clock);
         // read at the edge: values launched by the previous edge
         n++;
      end while (done !== 1'b1 && n < 20);
      start_valid <= 1'b0;
      `CHK("cycles", cyc, n)
      `CHK("pc_out", ep, pc_out)
      `CHK("pc_load", 1'b1, pc_load)
      `CHK("flags_wr_en", 1'b0, flags_wr_en)
      `CHK("rf_wr_en", ewr, rf_wr_en)
      if (ewr) begin
         `CHK("rf_wr_addr", ewa, rf_wr_addr)
         `CHK("rf_wr_data", ewdat, rf_wr_data)
      end
   endtask

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   always @(posedge clock) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      rst_n = 1'b0;
      start_valid = 1'b0;
      op_byte = 8'h00;
      arg1 = 8'h00;
      arg2 = 8'h00;
      pc_in = 16'h0000;
      flags_in = 8'h00;
      void'($urandom(26));
      for (i = 0; i < 256; i++) begin
         ref_mem[i] = 8'($urandom);
         rf.mem[i] = ref_mem[i];
      end
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      for (i = 0; i < 16; i++) begin
         fl = 8'($urandom);
         a1 = 8'($urandom);
         a2 = 8'($urandom);
         pc_in <= 16'($urandom);
         epc = 16'($urandom);
         run({i[3:0], 4'hd}, a1, a2, epc, fl, 8,
             cond(i[3:0], fl) ? {a1, a2} : epc + 16'h0003,
             1'b0, 8'h00, 8'h00);
      end
      for (i = 0; i < 32; i++) begin
         fl = 8'($urandom);
         a1 = (i == 8) ? 8'h7f : (i == 24) ? 8'h80 : 8'($urandom);
         epc = 16'($urandom);
         run({i[3:0], 4'hb}, a1, 8'($urandom), epc, fl, 6,
             epc + 16'h0002 + (cond(i[3:0], fl) ? {{8{a1[7]}}, a1} : 16'h0),
             1'b0, 8'h00, 8'h00);
      end
      for (i = 0; i < 4; i++) begin
         a1 = 8'($urandom) & 8'hfe;
         run(8'h30, a1, 8'($urandom), 16'($urandom), 8'($urandom), 8,
             {ref_mem[a1], ref_mem[a1 | 8'h01]},
             1'b0, 8'h00, 8'h00);
      end
      for (i = 0; i < 8; i++) begin
         dn = 4'($urandom);
         src = {1'b0, 7'($urandom)};
         a1 = i[0] ? 8'($urandom) : src;
         ewd = i[0] ? a1 : ref_mem[src];
         epc = 16'($urandom);
         run({dn, i[0] ? 4'hc : 4'h8}, a1, 8'($urandom), epc, 8'($urandom),
             4, epc + 16'h0002, 1'b1, {4'hc, dn}, ewd);
         ref_mem[{4'hc, dn}] = ewd;
         @(posedge clock);
         #1;
         `CHK("dst", ewd, rf.mem[{4'hc, dn}])
         `CHK("src", ref_mem[src], rf.mem[src])
      end
      @(posedge clock);
      op_byte <= 8'h21;
      start_valid <= 1'b1;
      @(posedge clock);
      start_valid <= 1'b0;
      @(posedge clock);
      `CHK("illegal", 1'b1, illegal)
      `CHK("ready", 1'b1, ready)
      `CHK("done", 1'b0, done)
      test_done();
   end
endmodule
`default_nettype wire
